// ---- common/apcs_pkg.sv ----
// Purpose: Constants shared by the audio port clock select block
// Assumes: Register index times four gives the AHB byte address
// Notes:   Effective source codes follow the ADC source field coding
package apcs_pkg;
    ////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index) and register width
    localparam logic [7:0] IDX_CLOCK_SOURCE_SELECT = 8'h08;
    localparam logic [7:0] IDX_PRIMARY_RX_CONFIG   = 8'h09;
    localparam logic [7:0] IDX_PRIMARY_TX_CONFIG   = 8'h0a;
    localparam logic [7:0] IDX_SECONDARY_CONFIG    = 8'h0b;
    localparam logic [7:0] IDX_POWER_DOWN_TWO      = 8'h33;
    localparam logic [7:0] IDX_EFFECTIVE_STATUS    = 8'h3e;
    localparam int         REG_W                   = 9;
    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int MASTER_BIT   = 5;
    localparam int SRC_LO       = 6;
    localparam int ADC_SRC_LO   = 2;
    localparam int OVERRIDE_BIT = 6;
    localparam int XTAL_PD_BIT  = 0;
    localparam int PLLA_PD_BIT  = 1;
    localparam int PLLB_PD_BIT  = 2;
    ////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [8:0] RST_CLOCK_SOURCE_SELECT = 9'h010;
    localparam logic [8:0] RST_PRIMARY_RX_CONFIG   = 9'h000;
    localparam logic [8:0] RST_PRIMARY_TX_CONFIG   = 9'h000;
    localparam logic [8:0] RST_SECONDARY_CONFIG    = 9'h0c0;
    localparam logic [8:0] RST_POWER_DOWN_TWO      = 9'h006;
    ////////////////////////////////////////////////////////////////////
    // Clock source codes, bus transfer code and pin count
    localparam logic [1:0] SRC_ADC_PIN  = 2'h0;
    localparam logic [1:0] SRC_PLL_A    = 2'h1;
    localparam logic [1:0] SRC_PLL_B    = 2'h2;
    localparam logic [1:0] SRC_MAIN_PIN = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int         PIN_W         = 10;
endpackage

// ---- rtl/apcs_sync.sv ----
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module apcs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1 <= '0;
            dout   <= '0;
        end else if (ce) begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// ---- rtl/apcs_clk_mux.sv ----
// Purpose: Registered four-way selection of sampled clock levels
// Assumes: Levels already synchronised to clk
// Notes:   Index follows the shared source coding
`timescale 1ns/1ps
module apcs_clk_mux (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic [3:0] levels,
    input  wire logic [1:0] sel,
    output logic            dout
);
    wire picked = levels[sel];

    always_ff @(posedge clk) begin
        if (srst) begin
            dout <= 1'b0;
        end else if (ce) begin
            dout <= picked;
        end
    end
endmodule

// ---- rtl/apcs_clock_select.sv ----
// Purpose: Clock source and master/slave selection for three audio ports
// Assumes: Single AHB-Lite slave, ce held high during bus transfers
// Notes:   Clock pins are sampled levels; dividers live elsewhere
// Notes on behaviour
// - Primary receive port master or slave from its config bit 5.
// - Slave primary receive port uses its own bit and frame clock pins.
// - Primary receive master source field 7:6: 00/11 main, 01 PLL A, 10 PLL B.
// - Digital audio receiver enabled forces primary receive master source to main.
// - Primary transmit port master or slave from its config bit 5.
// - Slave primary transmit bit clock: own pin, or receive pin if ADC on main.
// - Slave primary transmit frame clock comes from primary receive frame pin.
// - Transmit carrying receiver data uses PLL A; master mode advised.
// - Transmit carrying secondary receive data uses the ADC core clock source.
// - Secondary directions share one bit clock and one frame clock.
// - Secondary port master or slave from its config bit 5.
// - Slave secondary port uses its dedicated bit and frame clock pins.
// - Secondary master field 7:6, reset 11: ADC pin, PLL A, PLL B, main.
// - Secondary transmitter carrying receiver data selects PLL A automatically.
// - Receiver powered, other data: secondary limited to main or ADC pin.
// - Override bit 6 drops all automatic restrictions; fields used as written.
// - Oscillator clock is PLL reference only, not a selectable generator source.
// - Crystal output power-down bit 0: 0 powered up, 1 powered down.
// - ADC source field 3:2: ADC pin, PLL A, PLL B, main.
`timescale 1ns/1ps
module apcs_clock_select (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        dar_enabled,
    input  wire logic        ptx_carries_dar,
    input  wire logic        ptx_carries_srx,
    input  wire logic        sec_tx_carries_dar,
    input  wire logic        main_clock_pin,
    input  wire logic        adc_clock_pin,
    input  wire logic        pll_a_output,
    input  wire logic        pll_b_output,
    input  wire logic        oscillator_clock,
    input  wire logic        prx_bit_clock_pin,
    input  wire logic        prx_frame_clock_pin,
    input  wire logic        ptx_bit_clock_pin,
    input  wire logic        sec_bit_clock_pin,
    input  wire logic        sec_frame_clock_pin,
    output logic             prx_master,
    output logic             ptx_master,
    output logic             sec_master,
    output logic      [1:0]  prx_src_code,
    output logic      [1:0]  ptx_src_code,
    output logic      [1:0]  sec_src_code,
    output logic      [1:0]  adc_src_code,
    output logic             prx_gen_clk,
    output logic             ptx_gen_clk,
    output logic             sec_gen_clk,
    output logic             prx_slave_bclk,
    output logic             prx_slave_lrclk,
    output logic             ptx_slave_bclk,
    output logic             ptx_slave_lrclk,
    output logic             sec_slave_bclk,
    output logic             sec_slave_lrclk,
    output logic             pll_ref_clk,
    output logic             xtal_out_enable,
    output logic             pll_a_powerdown,
    output logic             pll_b_powerdown
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [8:0] clock_source_select;
    logic [8:0] primary_rx_port_config;
    logic [8:0] primary_tx_port_config;
    logic [8:0] secondary_port_config;
    logic [8:0] power_down_two;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [9:0] s_pins;

    apcs_sync #(
        .W(apcs_pkg::PIN_W)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .din  ({sec_frame_clock_pin, sec_bit_clock_pin, ptx_bit_clock_pin,
                prx_frame_clock_pin, prx_bit_clock_pin, oscillator_clock,
                main_clock_pin, pll_b_output, pll_a_output, adc_clock_pin}),
        .dout (s_pins)
    );

    wire [3:0] s_sources   = s_pins[3:0];
    wire       s_osc       = s_pins[4];
    wire       s_prx_bit   = s_pins[5];
    wire       s_prx_frame = s_pins[6];
    wire       s_ptx_bit   = s_pins[7];
    wire       s_sec_bit   = s_pins[8];
    wire       s_sec_frame = s_pins[9];

    ////////////////////////////////////////////////////////////////////
    // Source resolution; fields are only read here, never rewritten
    wire       ovr       = clock_source_select[apcs_pkg::OVERRIDE_BIT];
    wire [1:0] adc_field = clock_source_select[apcs_pkg::ADC_SRC_LO +: 2];
    wire [1:0] prx_field = primary_rx_port_config[apcs_pkg::SRC_LO +: 2];
    wire [1:0] sec_field = secondary_port_config[apcs_pkg::SRC_LO +: 2];
    wire       adc_pll   = (adc_field == apcs_pkg::SRC_PLL_A)
                         || (adc_field == apcs_pkg::SRC_PLL_B);

    // PLLs unusable for the ADC while the receiver runs
    wire [1:0] next_adc_src = (!ovr && dar_enabled && adc_pll)
                            ? apcs_pkg::SRC_ADC_PIN : adc_field;

    // Field codes 00 and 11 both mean the main pin here
    wire [1:0] prx_mapped = (prx_field == 2'h0) ? apcs_pkg::SRC_MAIN_PIN : prx_field;
    wire [1:0] next_prx_src = (!ovr && dar_enabled)
                            ? apcs_pkg::SRC_MAIN_PIN : prx_mapped;

    // No field of its own: override falls back to the ADC field
    wire [1:0] ptx_auto = ptx_carries_dar ? apcs_pkg::SRC_PLL_A
                                          : next_adc_src;
    wire [1:0] next_ptx_src = ovr ? adc_field : ptx_auto;

    wire [1:0] sec_limited = (sec_field == apcs_pkg::SRC_ADC_PIN)
                           ? apcs_pkg::SRC_ADC_PIN : apcs_pkg::SRC_MAIN_PIN;
    wire [1:0] sec_auto = sec_tx_carries_dar ? apcs_pkg::SRC_PLL_A
                        : dar_enabled        ? sec_limited
                                             : sec_field;
    wire [1:0] next_sec_src = ovr ? sec_field : sec_auto;

    // Transmit bit clock borrows the receive pin when the ADC runs on main
    wire next_ptx_bclk = (next_adc_src == apcs_pkg::SRC_MAIN_PIN)
                       ? s_prx_bit : s_ptx_bit;

    ////////////////////////////////////////////////////////////////////
    // Master clock generator inputs
    apcs_clk_mux u_prx_mux (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .levels (s_sources),
        .sel    (next_prx_src),
        .dout   (prx_gen_clk)
    );

    apcs_clk_mux u_ptx_mux (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .levels (s_sources),
        .sel    (next_ptx_src),
        .dout   (ptx_gen_clk)
    );

    // One generator feeds both secondary directions
    apcs_clk_mux u_sec_mux (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .levels (s_sources),
        .sel    (next_sec_src),
        .dout   (sec_gen_clk)
    );

    ////////////////////////////////////////////////////////////////////
    // Mode, source and slave clock outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            prx_master   <= 1'b0;
            ptx_master   <= 1'b0;
            sec_master   <= 1'b0;
            prx_src_code <= apcs_pkg::SRC_MAIN_PIN;
            ptx_src_code <= apcs_pkg::SRC_ADC_PIN;
            sec_src_code <= apcs_pkg::SRC_MAIN_PIN;
            adc_src_code <= apcs_pkg::SRC_ADC_PIN;
        end else if (ce) begin
            prx_master   <= primary_rx_port_config[apcs_pkg::MASTER_BIT];
            ptx_master   <= primary_tx_port_config[apcs_pkg::MASTER_BIT];
            sec_master   <= secondary_port_config[apcs_pkg::MASTER_BIT];
            prx_src_code <= next_prx_src;
            ptx_src_code <= next_ptx_src;
            sec_src_code <= next_sec_src;
            adc_src_code <= next_adc_src;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prx_slave_bclk  <= 1'b0;
            prx_slave_lrclk <= 1'b0;
            ptx_slave_bclk  <= 1'b0;
            ptx_slave_lrclk <= 1'b0;
            sec_slave_bclk  <= 1'b0;
            sec_slave_lrclk <= 1'b0;
            pll_ref_clk     <= 1'b0;
        end else if (ce) begin
            prx_slave_bclk  <= s_prx_bit;
            prx_slave_lrclk <= s_prx_frame;
            ptx_slave_bclk  <= next_ptx_bclk;
            ptx_slave_lrclk <= s_prx_frame;
            sec_slave_bclk  <= s_sec_bit;
            sec_slave_lrclk <= s_sec_frame;
            pll_ref_clk     <= s_osc;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            xtal_out_enable <= 1'b1;
            pll_a_powerdown <= 1'b1;
            pll_b_powerdown <= 1'b1;
        end else if (ce) begin
            xtal_out_enable <= !power_down_two[apcs_pkg::XTAL_PD_BIT];
            pll_a_powerdown <= power_down_two[apcs_pkg::PLLA_PD_BIT];
            pll_b_powerdown <= power_down_two[apcs_pkg::PLLB_PD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait, always OKAY
    logic       dph_write;
    logic [7:0] dph_idx;

    wire       take     = ce && hsel && hready && htrans[1];
    wire [7:0] addr_idx = haddr[9:2];
    wire [8:0] status   = {1'b0, dar_enabled, prx_src_code, ptx_src_code,
                           sec_src_code, adc_src_code[0]};
    wire [8:0] rd_mux   =
        (addr_idx == apcs_pkg::IDX_CLOCK_SOURCE_SELECT) ? clock_source_select    :
        (addr_idx == apcs_pkg::IDX_PRIMARY_RX_CONFIG)   ? primary_rx_port_config :
        (addr_idx == apcs_pkg::IDX_PRIMARY_TX_CONFIG)   ? primary_tx_port_config :
        (addr_idx == apcs_pkg::IDX_SECONDARY_CONFIG)    ? secondary_port_config  :
        (addr_idx == apcs_pkg::IDX_POWER_DOWN_TWO)      ? power_down_two         :
        (addr_idx == apcs_pkg::IDX_EFFECTIVE_STATUS)    ? status : 9'h000;
    wire       wr_en    = ce && dph_write;
    wire [8:0] wd       = hwdata[8:0];

    always_ff @(posedge clk) begin
        if (srst) begin
            dph_write <= 1'b0;
            dph_idx   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= ce;
            if (ce) begin
                dph_write <= take && hwrite;
                dph_idx   <= addr_idx;
                hrdata    <= (take && !hwrite) ? {23'h000000, rd_mux} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clock_source_select    <= apcs_pkg::RST_CLOCK_SOURCE_SELECT;
            primary_rx_port_config <= apcs_pkg::RST_PRIMARY_RX_CONFIG;
            primary_tx_port_config <= apcs_pkg::RST_PRIMARY_TX_CONFIG;
            secondary_port_config  <= apcs_pkg::RST_SECONDARY_CONFIG;
            power_down_two         <= apcs_pkg::RST_POWER_DOWN_TWO;
        end else if (wr_en) begin
            if (dph_idx == apcs_pkg::IDX_CLOCK_SOURCE_SELECT) clock_source_select <= wd;
            if (dph_idx == apcs_pkg::IDX_PRIMARY_RX_CONFIG) primary_rx_port_config <= wd;
            if (dph_idx == apcs_pkg::IDX_PRIMARY_TX_CONFIG) primary_tx_port_config <= wd;
            if (dph_idx == apcs_pkg::IDX_SECONDARY_CONFIG) secondary_port_config <= wd;
            // Crystal fitted means software leaves bit 0 clear
            if (dph_idx == apcs_pkg::IDX_POWER_DOWN_TWO) power_down_two <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_prx_master_bit: assert property (
        ce |=> prx_master == $past(primary_rx_port_config[apcs_pkg::MASTER_BIT]))
        else $error("primary receive master flag wrong");
    a_prx_field_map: assert property (
        (ce && !dar_enabled && prx_field == 2'h0) |=> prx_src_code == 2'h3)
        else $error("primary receive field 00 not main pin");
    a_prx_dar_force: assert property (
        (ce && dar_enabled && !ovr) |=> prx_src_code == apcs_pkg::SRC_MAIN_PIN)
        else $error("primary receive not forced to main pin");
    a_ptx_slave_bit: assert property (
        (ce && next_adc_src == 2'h3) |=> ptx_slave_bclk == $past(s_prx_bit))
        else $error("transmit bit clock not from receive pin");
    a_ptx_dar_plla: assert property (
        (ce && !ovr && ptx_carries_dar) |=> ptx_src_code == apcs_pkg::SRC_PLL_A)
        else $error("transmit not on PLL A");
    a_ptx_follow_adc: assert property (
        (ce && !ovr && !ptx_carries_dar && ptx_carries_srx)
            |=> ptx_src_code == adc_src_code)
        else $error("transmit source differs from ADC source");
    a_sec_dar_plla: assert property (
        (ce && !ovr && sec_tx_carries_dar) |=> sec_src_code == apcs_pkg::SRC_PLL_A)
        else $error("secondary not on PLL A");
    a_sec_restrict: assert property (
        (ce && !ovr && dar_enabled && !sec_tx_carries_dar)
            |=> (sec_src_code == 2'h3 || sec_src_code == 2'h0))
        else $error("secondary uses a PLL while receiver on");
    a_override_fields: assert property (
        (ce && ovr) |=> sec_src_code == $past(sec_field)
            && prx_src_code == $past(prx_mapped))
        else $error("override not honoured");
    a_xtal_powerdown: assert property (
        ce |=> xtal_out_enable == !$past(power_down_two[apcs_pkg::XTAL_PD_BIT]))
        else $error("crystal output enable wrong");
    a_field_kept: assert property (
        (ce && dar_enabled && !wr_en) |=> $stable(prx_field) && $stable(sec_field))
        else $error("stored field changed by forcing");
endmodule

// ---- bench/apcs_audio_host.sv ----
// Purpose: External audio processor driving the slave bit and frame clocks
// Assumes: Bit clock period 200 ns, frame clock toggles every 16 bit clocks
// Notes:   Clocks stand still while run is low so levels can be compared
`timescale 1ns/1ps
module apcs_audio_host (
    input  wire logic run,
    output logic      prx_bit_clock_pin,
    output logic      prx_frame_clock_pin,
    output logic      ptx_bit_clock_pin,
    output logic      sec_bit_clock_pin,
    output logic      sec_frame_clock_pin
);
    int cnt;
    ////////////////////////////////////////////////////////////////////
    // Odd start offset keeps pin edges off the 25 ns sampling grid
    initial begin
        cnt = 0;
        prx_bit_clock_pin = 1'b0;
        prx_frame_clock_pin = 1'b0;
        ptx_bit_clock_pin = 1'b1;
        sec_bit_clock_pin = 1'b1;
        sec_frame_clock_pin = 1'b1;
        #7;
        forever begin
            #100;
            if (run) begin
                cnt = cnt + 1;
                prx_bit_clock_pin = ~prx_bit_clock_pin;
                ptx_bit_clock_pin = ~prx_bit_clock_pin;
                sec_bit_clock_pin = ~sec_bit_clock_pin;
                if (cnt % 32 == 0) begin
                    prx_frame_clock_pin = ~prx_frame_clock_pin;
                    sec_frame_clock_pin = ~sec_frame_clock_pin;
                end
            end
        end
    end
endmodule

// ---- bench/tb_audio_port_clock_select.sv ----
// Purpose: Self-checking bench for the audio port clock select block
// Assumes: Zero-wait AHB-Lite slave, ce held high throughout
// Notes:   Source levels are static while outputs are compared
`timescale 1ns/1ps
module tb_audio_port_clock_select;
    logic clk, srst, hsel, hwrite, hreadyout, hresp, run, oscillator_clock;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, prx_src_code, ptx_src_code, sec_src_code, adc_src_code, ep, et, es, ea;
    logic [2:0] hsize;
    logic [3:0] lv;
    logic dar_enabled, ptx_carries_dar, ptx_carries_srx, sec_tx_carries_dar, d, sd;
    logic prx_master, ptx_master, sec_master, prx_gen_clk, ptx_gen_clk, sec_gen_clk;
    logic prx_slave_bclk, prx_slave_lrclk, ptx_slave_bclk, ptx_slave_lrclk;
    logic sec_slave_bclk, sec_slave_lrclk, pll_ref_clk, xtal_out_enable;
    logic pll_a_powerdown, pll_b_powerdown, prx_bit_clock_pin, prx_frame_clock_pin;
    logic ptx_bit_clock_pin, sec_bit_clock_pin, sec_frame_clock_pin;
    logic [7:0] ix [6];
    logic [8:0] r [6];
    int err_count, total_checks, seed;
    ////////////////////////////////////////////////////////////////////
    apcs_clock_select DUT (.clk, .srst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dar_enabled,
        .ptx_carries_dar, .ptx_carries_srx, .sec_tx_carries_dar, .main_clock_pin(lv[3]),
        .adc_clock_pin(lv[0]), .pll_a_output(lv[1]), .pll_b_output(lv[2]), .oscillator_clock,
        .prx_bit_clock_pin, .prx_frame_clock_pin, .ptx_bit_clock_pin, .sec_bit_clock_pin,
        .sec_frame_clock_pin, .prx_master, .ptx_master, .sec_master, .prx_src_code,
        .ptx_src_code, .sec_src_code, .adc_src_code, .prx_gen_clk, .ptx_gen_clk, .sec_gen_clk,
        .prx_slave_bclk, .prx_slave_lrclk, .ptx_slave_bclk, .ptx_slave_lrclk, .sec_slave_bclk,
        .sec_slave_lrclk, .pll_ref_clk, .xtal_out_enable, .pll_a_powerdown, .pll_b_powerdown);
    apcs_audio_host host (.run, .prx_bit_clock_pin, .prx_frame_clock_pin, .ptx_bit_clock_pin,
        .sec_bit_clock_pin, .sec_frame_clock_pin);
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction
    function automatic logic [1:0] e_adc(input logic [8:0] cs, input logic dr);
        if (!cs[6] && dr && (cs[3] ^ cs[2])) return 2'h0;
        return cs[3:2];
    endfunction
    function automatic logic [1:0] e_prx(input logic [8:0] cs, input logic [8:0] pc,
                                         input logic dr);
        if ((cs[6] || !dr) && (pc[7] ^ pc[6])) return pc[7:6];
        return 2'h3;
    endfunction
    function automatic logic [1:0] e_sec(input logic [8:0] cs, input logic [8:0] sc,
                                         input logic dr, input logic sdr);
        if (cs[6] || (!dr && !sdr)) return sc[7:6];
        if (sdr) return 2'h1;
        return (sc[7:6] == 2'h0) ? 2'h0 : 2'h3;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= apcs_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("bus_resp", 32'h2, {hreadyout, hresp});
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    initial begin
        clk = 0; srst = 1; hsel = 0; hwrite = 0; haddr = 0; hwdata = 0; htrans = 0;
        hsize = 3'h2; run = 0; oscillator_clock = 0; lv = 0; dar_enabled = 0;
        ptx_carries_dar = 0; ptx_carries_srx = 0; sec_tx_carries_dar = 0;
        err_count = 0; total_checks = 0; seed = 54066;
        ix = '{apcs_pkg::IDX_CLOCK_SOURCE_SELECT, apcs_pkg::IDX_PRIMARY_RX_CONFIG,
               apcs_pkg::IDX_PRIMARY_TX_CONFIG, apcs_pkg::IDX_SECONDARY_CONFIG,
               apcs_pkg::IDX_POWER_DOWN_TWO, 8'h20};
        r = '{9'h010, 9'h000, 9'h000, 9'h0c0, 9'h006, 9'h000};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("xtal_oe_rst", 1'b1, xtal_out_enable);
        chk("sec_src_rst", 2'h3, sec_src_code);
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, ad(ix[k]), 32'h0);
            chk("reset_value", {23'h0, r[k]}, rd);
        end
        $display("test reset_values done");
        // First three passes are forced corners: receiver on, override, receiver routing
        for (int i = 0; i < 40; i++) begin
            run <= 1'b1;
            d = (i < 3) ? 1'b1 : 1'($random(seed));
            sd = (i < 3) ? (i == 2) : 1'($random(seed));
            dar_enabled <= d;
            sec_tx_carries_dar <= sd;
            ptx_carries_dar <= 1'($random(seed));
            ptx_carries_srx <= 1'($random(seed));
            lv <= 4'($random(seed));
            oscillator_clock <= ~oscillator_clock;
            for (int k = 0; k < 5; k++) r[k] = 9'($random(seed));
            if (i < 3) begin
                r[0][6] = (i == 1);
                r[0][3:2] = 2'h1;
                r[1][7:6] = 2'h1;
                r[3][7:6] = 2'h2;
                r[4][0] = 1'b0;
            end
            for (int k = 0; k < 6; k++) bus(1'b1, ad(ix[k]), (k == 5) ? $random(seed) : r[k]);
            run <= 1'b0;
            repeat (10) @(posedge clk);
            ea = e_adc(r[0], d);
            ep = e_prx(r[0], r[1], d);
            et = r[0][6] ? r[0][3:2] : (ptx_carries_dar ? 2'h1 : ea);
            es = e_sec(r[0], r[3], d, sd);
            chk("masters", {r[1][5], r[2][5], r[3][5]}, {prx_master, ptx_master, sec_master});
            chk("prx_src", ep, prx_src_code);
            chk("ptx_src", et, ptx_src_code);
            chk("sec_src", es, sec_src_code);
            chk("adc_src", ea, adc_src_code);
            chk("gen_clks", {lv[ep], lv[et], lv[es]}, {prx_gen_clk, ptx_gen_clk, sec_gen_clk});
            chk("pll_ref", oscillator_clock, pll_ref_clk);
            chk("xtal_oe", !r[4][0], xtal_out_enable);
            chk("pll_pd", r[4][2:1], {pll_b_powerdown, pll_a_powerdown});
            chk("prx_slave", {prx_bit_clock_pin, prx_frame_clock_pin},
                {prx_slave_bclk, prx_slave_lrclk});
            chk("ptx_slave", {(ea == 2'h3) ? prx_bit_clock_pin : ptx_bit_clock_pin,
                prx_frame_clock_pin}, {ptx_slave_bclk, ptx_slave_lrclk});
            chk("sec_slave", {sec_bit_clock_pin, sec_frame_clock_pin},
                {sec_slave_bclk, sec_slave_lrclk});
            for (int k = 0; k < 6; k++) begin
                bus(1'b0, ad(ix[k]), 32'h0);
                chk("readback", {23'h0, r[k]}, rd);
            end
            bus(1'b0, ad(apcs_pkg::IDX_EFFECTIVE_STATUS), 32'h0);
            chk("status", {24'h0, d, ep, et, es, ea[0]}, rd);
        end
        $display("test random_config done");
        print_verdict();
    end
endmodule
